// ===== src/brownout_detect_control.v
/*
  brown-out detect control: threshold/enable registers, event and reset-cause
  flags, live status, low-power duty cycling and noise filter, APB slave.
  assumes an analog comparator (high = supply below threshold), a low-speed
  oscillator tick pulse already in this clock domain, and a boot config word.
*/
`timescale 1ns/1ns
`default_nettype none
`include "brownout_map.vh"

module brownout_detect_control
(
  input  wire        i_clk_sys,    // system clock, 10 MHz
  input  wire        i_srst,       // synchronous reset, active high
  input  wire        i_por,        // power-on reset, active high
  input  wire        i_low_speed_internal_osc_tick,  // slow oscillator tick, one-cycle pulse
  input  wire        i_cmp_below,  // async comparator, high = below
  input  wire [7:0]  i_boot_cfg,   // boot config word
  input  wire        i_psel,       // apb select
  input  wire        i_penable,    // apb enable
  input  wire        i_pwrite,     // apb direction
  input  wire [11:0] i_paddr,      // apb byte address
  input  wire [31:0] i_pwdata,     // apb write data
  output wire [31:0] o_prdata,     // apb read data
  output wire        o_pready,     // apb ready
  output wire        o_pslverr,    // apb error
  output wire        o_det_power,  // analog detector power
  output wire [1:0]  o_threshold,  // analog trip level select
  output reg         o_bo_reset,   // brown-out reset request, one pulse
  output wire        o_irq         // brown-out interrupt request
);

  localparam [31:0] LP1_CYC = `BO_LP_CYC(`BO_LP1_US);
  localparam [31:0] LP2_CYC = `BO_LP_CYC(`BO_LP2_US);
  localparam [31:0] LP3_CYC = `BO_LP_CYC(`BO_LP3_US);
  // reset images and filter lengths kept full width, sliced where used
  localparam [7:0]  LPFLT_RST  = `BO_LPFLT_RESET;
  localparam [7:0]  SYSCTL_RST = `BO_SYSCTL_RESET;
  localparam [31:0] FLT_SYS_N  = `BO_FLT_SYS_CYC;
  localparam [31:0] FLT_LOW_SPEED_INTERNAL_OSC_N = `BO_FLT_LOW_SPEED_INTERNAL_OSC_CYC;
  // unlock states
  localparam [1:0] UL_IDLE = 2'h0;
  localparam [1:0] UL_KEY1 = 2'h1;
  localparam [1:0] UL_OPEN = 2'h2;

  reg        det_en_reg;
  reg  [1:0] thr_reg;
  reg        rst_en_reg;
  reg        event_reg;
  reg        rstflag_reg;
  reg  [1:0] lp_reg;
  reg        flt_en_reg;
  reg  [3:0] sysctl_reg;
  reg  [1:0] ul_state_reg;
  reg  [1:0] settle_reg;
  reg  [5:0] flt_cnt_reg;
  reg        filt_reg;
  reg        filt_d_reg;
  reg        rst_pend_reg;
  reg  [18:0] period_reg;
  reg  [4:0] on_cnt_reg;
  reg        sampling_reg;
  reg        init_reg;
  reg [31:0] rdata_reg;
  wire       cmp_sync;

  // byte address to register index
  function [7:0] reg_index;
    input [11:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  wire [7:0] idx   = reg_index(i_paddr);
  wire       wr    = i_psel & i_penable & i_pwrite;
  wire       rd    = i_psel & i_penable & ~i_pwrite;
  wire       known = (idx == `BO_IDX_CTRL) | (idx == `BO_IDX_LPFLT) |
                     (idx == `BO_IDX_TIMED) | (idx == `BO_IDX_SYSCTL);
  wire       unlocked = (ul_state_reg == UL_OPEN);
  wire       wr_ctrl  = wr & (idx == `BO_IDX_CTRL) & unlocked;
  wire       wr_lpflt = wr & (idx == `BO_IDX_LPFLT) & unlocked;
  wire       wr_timed = wr & (idx == `BO_IDX_TIMED);
  wire       pwrdn    = sysctl_reg[`BO_F_PWRDN];
  wire       slowclk  = sysctl_reg[`BO_F_SLOWCLK];

  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~known;
  assign o_prdata  = rdata_reg;

  // comparator into system domain
  brownout_sync u_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (i_cmp_below),
    .o_sync    (cmp_sync)
  );

  // timed-access unlock: key1 then key2 opens one protected write
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
      ul_state_reg <= UL_IDLE;
    else
    begin
      case (ul_state_reg)
        UL_IDLE:
          if (wr_timed && i_pwdata[7:0] == `BO_UNLOCK_KEY1)
            ul_state_reg <= UL_KEY1;
        UL_KEY1:
          if (wr_timed && i_pwdata[7:0] == `BO_UNLOCK_KEY2)
            ul_state_reg <= UL_OPEN;
          else if (wr)
            ul_state_reg <= UL_IDLE;
        UL_OPEN:
          if (wr)
            ul_state_reg <= UL_IDLE;    // one write per unlock
        default:
          ul_state_reg <= UL_IDLE;
      endcase
    end
  end

  // low-power duty cycling: detector powered for a short window each period
  wire [31:0] period_len = (lp_reg == 2'b01) ? LP1_CYC :
                           (lp_reg == 2'b10) ? LP2_CYC : LP3_CYC;
  wire        lp_mode    = (lp_reg != 2'b00);
  always @(posedge i_clk_sys)
  begin
    if (i_srst || !det_en_reg || !lp_mode)
    begin
      period_reg   <= 19'h00000;
      on_cnt_reg   <= 5'h00;
      sampling_reg <= 1'b0;
    end
    else if (period_reg >= period_len[18:0] - 19'h00001)
    begin
      period_reg   <= 19'h00000;
      sampling_reg <= 1'b1;
      on_cnt_reg   <= 5'h00;
    end
    else
    begin
      period_reg <= period_reg + 19'h00001;
      if (sampling_reg && i_low_speed_internal_osc_tick)
      begin
        // window of 16 slow ticks sets the unfiltered minimum pulse
        if (on_cnt_reg == `BO_ON_LOW_SPEED_INTERNAL_OSC_CYC - 1)
          sampling_reg <= 1'b0;
        on_cnt_reg <= on_cnt_reg + 5'h01;
      end
    end
  end

  assign o_det_power = det_en_reg & (~lp_mode | sampling_reg);
  assign o_threshold = thr_reg;

  // settle counter: output ignored until 3 slow ticks after power-up
  always @(posedge i_clk_sys)
  begin
    if (i_srst || !o_det_power)
      settle_reg <= 2'h0;
    else if (i_low_speed_internal_osc_tick && settle_reg != `BO_SETTLE_LOW_SPEED_INTERNAL_OSC_CYC)
      settle_reg <= settle_reg + 2'h1;
  end
  wire cmp_valid = o_det_power & (settle_reg == `BO_SETTLE_LOW_SPEED_INTERNAL_OSC_CYC);

  // noise filter: sys-clock count in fast normal mode, slow ticks otherwise
  wire use_slow = pwrdn | lp_mode | slowclk;
  wire flt_on   = flt_en_reg | pwrdn;
  wire [5:0] flt_need = use_slow ? FLT_LOW_SPEED_INTERNAL_OSC_N[5:0] : FLT_SYS_N[5:0];
  wire       flt_step = use_slow ? i_low_speed_internal_osc_tick : 1'b1;
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      flt_cnt_reg <= 6'h00;
      filt_reg    <= 1'b0;
    end
    else if (!cmp_valid)
    begin
      // a lost sample in low-power mode keeps the last level
      flt_cnt_reg <= 6'h00;
      if (!det_en_reg)
        filt_reg <= 1'b0;
    end
    else if (cmp_sync == filt_reg)
      flt_cnt_reg <= 6'h00;
    else if (!flt_on)
      filt_reg <= cmp_sync;
    else if (flt_step)
    begin
      if (flt_cnt_reg == flt_need - 6'h01)
      begin
        filt_reg    <= cmp_sync;
        flt_cnt_reg <= 6'h00;
      end
      else
        flt_cnt_reg <= flt_cnt_reg + 6'h01;
    end
  end

  wire crossing  = (filt_reg != filt_d_reg) & det_en_reg;   // off is no crossing
  wire fall_trip = filt_reg & ~filt_d_reg;

  // reset request when a drop is seen with reset enabled
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      filt_d_reg   <= 1'b0;
      o_bo_reset   <= 1'b0;
      rst_pend_reg <= 1'b0;
    end
    else
    begin
      filt_d_reg   <= filt_reg;
      o_bo_reset   <= fall_trip & rst_en_reg;
      rst_pend_reg <= fall_trip & rst_en_reg;
    end
  end

  // reset-cause flag: kept across other resets, set on a brown-out reset
  always @(posedge i_clk_sys)
  begin
    if (i_por)
      rstflag_reg <= 1'b0;
    else if (rst_pend_reg)
      rstflag_reg <= 1'b1;                         // set beats clear
    else if (wr_ctrl)
      rstflag_reg <= i_pwdata[`BO_F_RSTFLAG];
  end

  // control registers; reset reloads the config-owned fields
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      det_en_reg <= 1'b0;
      thr_reg    <= 2'b00;
      rst_en_reg <= 1'b0;
      event_reg  <= 1'b0;
      init_reg   <= 1'b1;
      sysctl_reg <= SYSCTL_RST[3:0];
    end
    else if (init_reg)
    begin
      // strap caught after release of reset
      det_en_reg <= i_boot_cfg[`BO_F_DETEN];
      thr_reg    <= i_boot_cfg[`BO_F_THR_HI:`BO_F_THR_LO];
      rst_en_reg <= i_boot_cfg[`BO_F_RSTEN];
      event_reg  <= i_boot_cfg[`BO_F_DETEN] & ~i_boot_cfg[`BO_F_RSTEN] &
                    cmp_sync;
      init_reg   <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        det_en_reg <= i_pwdata[`BO_F_DETEN];
        thr_reg    <= i_pwdata[`BO_F_THR_HI:`BO_F_THR_LO];
        rst_en_reg <= i_pwdata[`BO_F_RSTEN];
      end
      if (crossing)
        event_reg <= 1'b1;                         // set beats clear
      else if (wr_ctrl)
        event_reg <= i_pwdata[`BO_F_EVENT];
      if (wr && idx == `BO_IDX_SYSCTL)
        sysctl_reg <= i_pwdata[3:0];
    end
  end

  // low-power and filter register; filter enable defaults on
  always @(posedge i_clk_sys)
  begin
    if (i_por)
    begin
      lp_reg     <= LPFLT_RST[`BO_F_LP_HI:`BO_F_LP_LO];
      flt_en_reg <= LPFLT_RST[`BO_F_FLTEN];
    end
    else if (wr_lpflt)
    begin
      lp_reg     <= i_pwdata[`BO_F_LP_HI:`BO_F_LP_LO];
      flt_en_reg <= i_pwdata[`BO_F_FLTEN];
    end
  end

  assign o_irq = event_reg & sysctl_reg[`BO_F_IRQEN] &
                 sysctl_reg[`BO_F_GIRQEN];

  // registered read data during setup phase
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
      rdata_reg <= 32'h00000000;
    else if (i_psel && !i_penable)
    begin
      rdata_reg <= 32'h00000000;
      case (idx)
        `BO_IDX_CTRL:
          rdata_reg[7:0] <= {det_en_reg, 1'b0, thr_reg, event_reg, rst_en_reg,
                             rstflag_reg, filt_reg & det_en_reg};
        `BO_IDX_LPFLT:
          rdata_reg[7:0] <= {5'h00, lp_reg, flt_en_reg};
        `BO_IDX_SYSCTL:
          rdata_reg[7:0] <= {4'h0, sysctl_reg};
        default:
          rdata_reg <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== src/brownout_map.vh
/*
  register map, field positions, reset values and timing counts for the
  brown-out detect control block. assumes a 10 MHz system clock.
*/
`ifndef BROWNOUT_MAP_VH
`define BROWNOUT_MAP_VH

// register indices as printed; byte address is four times the index
`define BO_IDX_CTRL          8'ha3
`define BO_IDX_LPFLT         8'hab
`define BO_IDX_TIMED         8'hb0
`define BO_IDX_SYSCTL        8'hb1
`define BO_ADDR_CTRL         12'h28c
`define BO_ADDR_LPFLT        12'h2ac
`define BO_ADDR_TIMED        12'h2c0
`define BO_ADDR_SYSCTL       12'h2c4

// control/status field positions
`define BO_F_DETEN           7
`define BO_F_THR_HI          5
`define BO_F_THR_LO          4
`define BO_F_EVENT           3
`define BO_F_RSTEN           2
`define BO_F_RSTFLAG         1
`define BO_F_BELOW           0
// low-power/filter field positions
`define BO_F_LP_HI           2
`define BO_F_LP_LO           1
`define BO_F_FLTEN           0
// system control field positions (irq enables, clock source, power-down)
`define BO_F_IRQEN           0
`define BO_F_GIRQEN          1
`define BO_F_SLOWCLK         2
`define BO_F_PWRDN           3

`define BO_LPFLT_RESET       8'h01
`define BO_SYSCTL_RESET      8'h00
`define BO_UNLOCK_KEY1       8'haa
`define BO_UNLOCK_KEY2       8'h55

// timing
`define BO_CLK_NS            100
`define BO_FLT_SYS_CYC       32
`define BO_FLT_LOW_SPEED_INTERNAL_OSC_CYC      2
`define BO_SETTLE_LOW_SPEED_INTERNAL_OSC_CYC   3
`define BO_LP1_US            1600
`define BO_LP2_US            6400
`define BO_LP3_US            25600
`define BO_LP_CYC(us)        (((us) * 1000) / `BO_CLK_NS)
`define BO_ON_LOW_SPEED_INTERNAL_OSC_CYC       16

`endif

// ===== src/brownout_sync.v
/*
  two-flop synchroniser for one asynchronous level.
  assumes the input may change at any time relative to i_clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none

module brownout_sync
(
  input  wire i_clk_sys, // system clock
  input  wire i_srst,    // synchronous reset, active high
  input  wire i_async,   // asynchronous level
  output reg  o_sync     // synchronised level
);

  reg meta_reg;

  // first stage feeds only the second stage
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      meta_reg <= 1'b0;
      o_sync   <= 1'b0;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ===== test/brownout_detect_control_checker.sv
/*
  port checker for the brown-out detect control block.
  assumes the map header is on the include path; bound at the foot.
*/
`timescale 1ns/1ns
`default_nettype none
`include "brownout_map.vh"

module brownout_detect_control_checker
(
  input wire logic        i_clk_sys,   // system clock
  input wire logic        i_srst,      // sync reset
  input wire logic        i_low_speed_internal_osc_tick, // slow tick
  input wire logic [7:0]  i_boot_cfg,  // config word
  input wire logic        i_psel,      // apb select
  input wire logic        i_penable,   // apb enable
  input wire logic        i_pwrite,    // apb direction
  input wire logic [11:0] i_paddr,     // apb address
  input wire logic [31:0] i_pwdata,    // apb write data
  input wire logic        o_det_power, // detector power
  input wire logic [1:0]  o_threshold, // trip select
  input wire logic        o_bo_reset,  // reset pulse
  input wire logic        o_irq        // interrupt
);
  logic       wr;
  logic       ctrl_wr;
  logic [1:0] thr_wd;
  logic       key1_reg;
  logic       armed_reg;
  logic [1:0] settle_reg;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  // decoded write strobes
  assign wr      = i_psel && i_penable && i_pwrite;
  assign ctrl_wr = wr && (i_paddr == `BO_ADDR_CTRL);
  assign thr_wd  = i_pwdata[5:4];

  // unlock tracker; reads neither advance nor abort it
  always_ff @(posedge i_clk_sys)
    if (i_srst)
    begin
      key1_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end
    else if (wr)
    begin
      key1_reg  <= (i_paddr == `BO_ADDR_TIMED) && (i_pwdata[7:0] == `BO_UNLOCK_KEY1);
      armed_reg <= key1_reg && (i_paddr == `BO_ADDR_TIMED) && (i_pwdata[7:0] == `BO_UNLOCK_KEY2);
    end

  // slow ticks since power-up, saturating at three
  always_ff @(posedge i_clk_sys)
    if (i_srst || !o_det_power)
      settle_reg <= 2'h0;
    else if (i_low_speed_internal_osc_tick && (settle_reg != 2'h3))
      settle_reg <= settle_reg + 2'h1;

  enable_off_a: assert property (ctrl_wr && armed_reg && !i_pwdata[7] |=> !o_det_power)
    else $error("detector powered after disable");
  settle_a: assert property (o_bo_reset |-> settle_reg >= 2'h2)
    else $error("reset during settle time");
  thr_write_a: assert property (ctrl_wr && armed_reg |=> o_threshold == $past(thr_wd))
    else $error("threshold not taken");
  locked_write_a: assert property (ctrl_wr && !armed_reg |=> $stable(o_threshold))
    else $error("locked write took effect");
  cfg_load_a: assert property ($fell(i_srst) |=> o_threshold == i_boot_cfg[5:4])
    else $error("threshold not loaded from config");
  reset_pulse_a: assert property (o_bo_reset |=> !o_bo_reset)
    else $error("reset pulse too long");
  irq_mask_a: assert property (wr && i_paddr == `BO_ADDR_SYSCTL && !i_pwdata[1] |=> !o_irq)
    else $error("irq with global enable off");
  irq_hold_a: assert property ($fell(o_irq) |-> $past(wr))
    else $error("event cleared without write");
endmodule

bind brownout_detect_control brownout_detect_control_checker chk (.i_clk_sys, .i_srst,
  .i_low_speed_internal_osc_tick, .i_boot_cfg, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .o_det_power, .o_threshold, .o_bo_reset, .o_irq);
`default_nettype wire

// ===== test/brownout_supply_model.sv
/*
  supply comparator and slow oscillator model.
  assumes the bench sets the supply in mV.
*/
`timescale 1ns/1ns
`default_nettype none

module brownout_supply_model
#(
  parameter int LOW_SPEED_INTERNAL_OSC_DIV = 8 // clocks per slow tick
)
(
  input  wire logic        i_clk_sys, // system clock
  input  wire logic        i_power,   // detector powered
  input  wire logic [1:0]  i_thr,     // trip select
  input  wire logic [15:0] i_vdd_mv,  // supply in mV
  output logic             o_below,   // high = below trip
  output logic             o_tick     // slow tick
);
  logic [15:0] trip_mv;
  logic        junk_reg = 1'b0;
  int          div_cnt  = 0;

  // trip level per code: 4.3, 3.8, 2.7, 2.2 V
  always_comb
    case (i_thr)
      2'h0:    trip_mv = 16'h10cc;
      2'h1:    trip_mv = 16'h0ed8;
      2'h2:    trip_mv = 16'h0a8c;
      default: trip_mv = 16'h0898;
    endcase

  // unpowered output means nothing, so it toggles
  assign o_below = i_power ? (i_vdd_mv < trip_mv) : junk_reg;

  // free-running slow oscillator
  always @(posedge i_clk_sys)
  begin
    junk_reg <= !junk_reg;
    div_cnt  <= (div_cnt == LOW_SPEED_INTERNAL_OSC_DIV - 1) ? 0 : div_cnt + 1;
    o_tick   <= (div_cnt == LOW_SPEED_INTERNAL_OSC_DIV - 1);
  end
endmodule
`default_nettype wire

// ===== test/test_brownout_detect_control.sv
/*
  directed bench for the brown-out detect control block.
  assumes the supply model and bound checker are compiled too.
*/
`timescale 1ns/1ns
`default_nettype none
`include "brownout_map.vh"

module test_brownout_detect_control;
  logic        i_clk_sys, i_srst, i_por, i_psel, i_penable, i_pwrite;
  logic        i_low_speed_internal_osc_tick, i_cmp_below, o_pready, o_pslverr;
  logic        o_det_power, o_bo_reset, o_irq, err;
  logic [1:0]  o_threshold;
  logic [7:0]  i_boot_cfg;
  logic [11:0] i_paddr;
  logic [15:0] vdd;
  logic [15:0] trip [4] = '{16'h10cc, 16'h0ed8, 16'h0a8c, 16'h0898};
  logic [31:0] i_pwdata, o_prdata, q, e;
  int          mismatches = 0, total_checks = 0, n, a, b;

  brownout_detect_control dut (.i_clk_sys, .i_srst, .i_por, .i_low_speed_internal_osc_tick, .i_cmp_below,
    .i_boot_cfg, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .o_det_power, .o_threshold, .o_bo_reset, .o_irq);
  brownout_supply_model supply (.i_clk_sys, .i_power(o_det_power), .i_thr(o_threshold),
    .i_vdd_mv(vdd), .o_below(i_cmp_below), .o_tick(i_low_speed_internal_osc_tick));

  // compare and tally
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; psel drops for a cycle after it
  task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= ad;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    // no local limit: a hung wait is ended by the watchdog
    do
    begin
      @(posedge i_clk_sys);
    end
    while (o_pready !== 1'b1);
    q   = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  // protected write: unlock keys first
  task automatic uwr(input logic [11:0] ad, input logic [31:0] d);
    apb(`BO_ADDR_TIMED, 1'b1, 32'h000000aa);
    apb(`BO_ADDR_TIMED, 1'b1, 32'h00000055);
    apb(ad, 1'b1, d);
  endtask

  task automatic chk_rd(input logic [11:0] ad, input logic [31:0] exp);
    apb(ad, 1'b0, 32'h0);
    check(q, exp);
  endtask

  // wait for a power level, counting cycles
  task automatic wait_pow(input logic v, output int c);
    c = 0;
    while (o_det_power !== v && c < 40000)
    begin
      @(negedge i_clk_sys);
      c++;
    end
  endtask

  task automatic do_reset(input logic p);
    i_srst <= 1'b1;
    i_por  <= p;
    repeat (10) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    i_por  <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask

  task end_sim;
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // system clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // watchdog well beyond the expected run
  initial
  begin
    repeat (90000) @(posedge i_clk_sys);
    mismatches++;
    end_sim;
  end

  // main sequence
  initial
  begin
    {i_srst, i_por, i_psel, i_penable, i_pwrite} = 5'h18;
    i_paddr    = 12'h0;
    i_pwdata   = 32'h0;
    i_boot_cfg = 8'h90;
    vdd        = 16'h1388;
    @(posedge i_clk_sys);
    do_reset(1'b1);
    chk_rd(`BO_ADDR_CTRL, 32'h90);
    chk_rd(`BO_ADDR_LPFLT, 32'h01);
    check({31'h0, err}, 32'h0);
    apb(12'h000, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
    check(q, 32'h0);
    apb(`BO_ADDR_CTRL, 1'b1, 32'h0);
    chk_rd(`BO_ADDR_CTRL, 32'h90);
    for (int t = 0; t < 4; t++)
    begin
      e = 32'h80 | (t << 4);
      uwr(`BO_ADDR_CTRL, e);
      vdd <= trip[t] - 16'h0032;
      repeat (60) @(posedge i_clk_sys);
      chk_rd(`BO_ADDR_CTRL, e | 32'h9);
      uwr(`BO_ADDR_CTRL, e);
      repeat (60) @(posedge i_clk_sys);
      chk_rd(`BO_ADDR_CTRL, e | 32'h1);
      vdd <= trip[t] + 16'h0032;
      repeat (60) @(posedge i_clk_sys);
      chk_rd(`BO_ADDR_CTRL, e | 32'h8);
    end
    // dip shorter than the 32-clock filter
    uwr(`BO_ADDR_CTRL, 32'hb0);
    vdd <= 16'h0834;
    repeat (20) @(posedge i_clk_sys);
    vdd <= 16'h1388;
    repeat (60) @(posedge i_clk_sys);
    chk_rd(`BO_ADDR_CTRL, 32'hb0);
    apb(`BO_ADDR_SYSCTL, 1'b1, 32'h3);
    vdd <= 16'h07d0;
    repeat (60) @(posedge i_clk_sys);
    check({31'h0, o_irq}, 32'h1);
    apb(`BO_ADDR_SYSCTL, 1'b1, 32'h1);
    check({31'h0, o_irq}, 32'h0);
    uwr(`BO_ADDR_CTRL, 32'hb0);
    apb(`BO_ADDR_SYSCTL, 1'b1, 32'h3);
    check({31'h0, o_irq}, 32'h0);
    uwr(`BO_ADDR_CTRL, 32'h30);
    check({31'h0, o_det_power}, 32'h0);
    repeat (60) @(posedge i_clk_sys);
    chk_rd(`BO_ADDR_CTRL, 32'h30);
    uwr(`BO_ADDR_LPFLT, 32'h0);
    chk_rd(`BO_ADDR_LPFLT, 32'h0);
    // brown-out reset, then a warm and a cold reset
    vdd <= 16'h1388;
    uwr(`BO_ADDR_CTRL, 32'hb4);
    repeat (60) @(posedge i_clk_sys);
    vdd <= 16'h07d0;
    n = 0;
    while (o_bo_reset !== 1'b1 && n < 300)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    check({31'h0, o_bo_reset}, 32'h1);
    repeat (2) @(posedge i_clk_sys);
    do_reset(1'b0);
    repeat (60) @(posedge i_clk_sys);
    chk_rd(`BO_ADDR_CTRL, 32'h9b);
    vdd <= 16'h1388;
    do_reset(1'b1);
    chk_rd(`BO_ADDR_CTRL, 32'h90);
    // slow clock source: a 24-cycle dip passes the 2-tick filter
    repeat (60) @(posedge i_clk_sys);
    apb(`BO_ADDR_SYSCTL, 1'b1, 32'h4);
    vdd <= 16'h07d0;
    repeat (24) @(posedge i_clk_sys);
    vdd <= 16'h1388;
    repeat (60) @(posedge i_clk_sys);
    chk_rd(`BO_ADDR_CTRL, 32'h98);
    // power-down filters even with the filter off: 4-cycle dip lost
    uwr(`BO_ADDR_LPFLT, 32'h0);
    uwr(`BO_ADDR_CTRL, 32'h90);
    apb(`BO_ADDR_SYSCTL, 1'b1, 32'h8);
    vdd <= 16'h07d0;
    repeat (4) @(posedge i_clk_sys);
    vdd <= 16'h1388;
    repeat (60) @(posedge i_clk_sys);
    chk_rd(`BO_ADDR_CTRL, 32'h90);
    // low-power mode 1: rise-to-rise power period
    uwr(`BO_ADDR_LPFLT, 32'h3);
    wait_pow(1'b0, n);
    wait_pow(1'b1, n);
    wait_pow(1'b0, a);
    wait_pow(1'b1, b);
    check(a + b, 32'h3e80);
    end_sim;
  end
endmodule
`default_nettype wire
